// file: hdl/event_fabric_map.svh
`ifndef EVENT_FABRIC_MAP_SVH
`define EVENT_FABRIC_MAP_SVH
`define TSEL_SOFTWARE 4'h0
`define TSEL_SUB_A 4'h1
`define TSEL_SUB_B 4'h2
`define TSEL_SERIAL_FIRST 4'h3
`define TSEL_SERIAL_LAST 4'he
`define TSEL_CONVERTER 4'hf
`define CHAN_NONE 4'h0
`define CHAN_P2P_LAST 4'h4
`define CHAN_P2P_FIVE 4'h6
`define CHAN_SPLIT_A 4'h7
`define CHAN_SPLIT_B 4'h8
`define IRQ_SYSTEM_CONTROL_UNIT 5'h00
`define IRQ_LOW_FREQ 5'h1e
`define IRQ_DMA 5'h1f
`endif

// file: hdl/event_fabric_pkg.sv
package event_fabric_pkg;
  typedef logic [3:0] chan_id_t;
  typedef logic [3:0] tsel_t;
endpackage

// file: hdl/event_fabric.sv
// Operation
// [RULE1] carry events from publishers to subscribers
// [RULE2] fixed routes plus programmable routes
// [RULE3] static peripheral events become interrupt lines
// [RULE4] peripheral events can trigger DMA
// [RULE5] generic events trigger other peripherals directly
// [RULE6] trigger select 0 software, 1/2 subscriber ports
// [RULE7] codes 3-14 serial publishers, 15 converter
// [RULE8] generic route point-to-point or two-way splitter
// [RULE9] each publisher selects its generic channel
// [RULE10] generic destinations: peripheral, DMA, processor
// [RULE11] channel id zero connects nothing
// [RULE12] ids 1-4 and 6 point-to-point
// [RULE13] ids 7 and 8 are splitters
// [RULE14] interrupts 0 system, 31 DMA, 30 low-freq
// [RULE15] one trigger select field per DMA channel
// [RULE16] unlisted codes route and trigger nothing
`include "event_fabric_map.svh"
module event_fabric
  import event_fabric_pkg::*;
#(
  parameter int NUM_PUB = 4,
  parameter int NUM_DMA_CH = 3
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [NUM_PUB-1:0] i_pub_event,
  input wire logic [4*NUM_PUB-1:0] i_generic_route_channel_id,
  input wire logic [NUM_DMA_CH-1:0] i_sw_trigger,
  input wire logic [4*NUM_DMA_CH-1:0] i_dma_trigger_select,
  input wire logic [11:0] i_serial_pub,
  input wire logic i_converter_dma_trigger,
  input wire logic i_system_control_unit_irq,
  input wire logic i_dma_irq,
  input wire logic i_low_freq_subsystem_irq,
  input wire logic i_rtc_irq,
  input wire logic i_independent_watchdog_irq,
  input wire logic [31:0] i_other_irq,
  output logic [5:0] o_generic_channel,
  output logic [1:0] o_split_second,
  output logic o_generic_subscriber_port_a,
  output logic o_generic_subscriber_port_b,
  output logic o_cpu_generic_event,
  output logic [NUM_DMA_CH-1:0] o_dma_trigger,
  output logic [31:0] o_irq
);
  if (NUM_PUB < 1 || NUM_DMA_CH < 1) begin : g_bad_size
    $error("bad fabric size");
  end

  typedef struct packed {
    logic [5:0] chan;
    logic [1:0] split2;
    logic sub_a;
    logic sub_b;
    logic cpu_ev;
    logic [NUM_DMA_CH-1:0] trig;
    logic [31:0] irq;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic [5:0] chan_or;
  logic [NUM_PUB*6-1:0] pub_chan;

  // per-publisher channel decode
  genvar g;
  generate
    for (g = 0; g < NUM_PUB; g++) begin : g_pub
      chan_id_t id;
      logic [5:0] hit;
      assign id = i_generic_route_channel_id[4*g +: 4]; // see [RULE9]
      always_comb begin
        hit = 6'h00;
        if (i_pub_event[g]) begin // see [RULE1]
          unique case (id)
            `CHAN_NONE: hit = 6'h00; // see [RULE11]
            4'h1, 4'h2, 4'h3, `CHAN_P2P_LAST: hit[id[2:0] - 3'h1] = 1'b1; // see [RULE12]
            `CHAN_P2P_FIVE: hit[4] = 1'b1; // see [RULE12]
            `CHAN_SPLIT_A: hit[4] = 1'b1; // see [RULE13]
            `CHAN_SPLIT_B: hit[5] = 1'b1; // see [RULE13]
            default: hit = 6'h00; // see [RULE16]
          endcase
        end
      end
      assign pub_chan[6*g +: 6] = hit;
    end
  endgenerate

  always_comb begin
    chan_or = 6'h00;
    for (int i = 0; i < NUM_PUB; i++) begin
      chan_or = chan_or | pub_chan[6*i +: 6]; // see [RULE2]
    end
  end

  always_comb begin
    logic sel_split5;
    tsel_t ts;
    sel_split5 = 1'b0;
    ts = 4'h0;
    nxt_st = st_ff;
    for (int i = 0; i < NUM_PUB; i++) begin
      if (i_pub_event[i] && i_generic_route_channel_id[4*i +: 4] == `CHAN_SPLIT_A) begin
        sel_split5 = 1'b1;
      end
    end
    nxt_st.chan = chan_or; // see [RULE5]
    nxt_st.split2 = {chan_or[5], sel_split5}; // see [RULE8]
    nxt_st.sub_a = chan_or[0]; // see [RULE10]
    nxt_st.sub_b = chan_or[1]; // see [RULE10]
    nxt_st.cpu_ev = chan_or[2]; // see [RULE10]
    for (int c = 0; c < NUM_DMA_CH; c++) begin
      ts = i_dma_trigger_select[4*c +: 4]; // see [RULE15]
      if (ts == `TSEL_SOFTWARE) begin
        nxt_st.trig[c] = i_sw_trigger[c]; // see [RULE6]
      end else if (ts == `TSEL_SUB_A) begin
        nxt_st.trig[c] = chan_or[0]; // see [RULE6]
      end else if (ts == `TSEL_SUB_B) begin
        nxt_st.trig[c] = chan_or[1]; // see [RULE6]
      end else if (ts == `TSEL_CONVERTER) begin
        nxt_st.trig[c] = i_converter_dma_trigger; // see [RULE7]
      end else begin
        nxt_st.trig[c] = i_serial_pub[ts - `TSEL_SERIAL_FIRST]; // see [RULE4] see [RULE7]
      end
    end
    nxt_st.irq = i_other_irq; // see [RULE3]
    nxt_st.irq[`IRQ_SYSTEM_CONTROL_UNIT] = i_system_control_unit_irq; // see [RULE14]
    nxt_st.irq[`IRQ_DMA] = i_dma_irq; // see [RULE14]
    nxt_st.irq[`IRQ_LOW_FREQ] = i_low_freq_subsystem_irq | i_rtc_irq | i_independent_watchdog_irq; // see [RULE14]
    if (i_sys_rst) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    st_ff <= nxt_st;
  end

  assign o_generic_channel = st_ff.chan;
  assign o_split_second = st_ff.split2;
  assign o_generic_subscriber_port_a = st_ff.sub_a;
  assign o_generic_subscriber_port_b = st_ff.sub_b;
  assign o_cpu_generic_event = st_ff.cpu_ev;
  assign o_dma_trigger = st_ff.trig;
  assign o_irq = st_ff.irq;
endmodule

// file: tb/dma_trigger_sink.sv
module dma_trigger_sink (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_trig,
  output int o_count
);
  timeunit 1ns / 1ns;
  always_ff @(posedge i_clk) o_count <= i_sys_rst ? 0 : o_count + int'(i_trig);
endmodule

// file: tb/event_fabric_sva.sv
module event_fabric_sva (
  input wire logic i_clk, i_sys_rst, i_system_control_unit_irq, i_dma_irq,
  input wire logic [3:0] i_pub_event,
  input wire logic [15:0] i_generic_route_channel_id,
  input wire logic [2:0] i_sw_trigger, o_dma_trigger,
  input wire logic [11:0] i_serial_pub, i_dma_trigger_select,
  input wire logic [31:0] i_other_irq, o_irq,
  input wire logic [5:0] o_generic_channel,
  input wire logic [1:0] o_split_second
);
  timeunit 1ns / 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire logic [3:0] id = i_generic_route_channel_id[3:0], ts = i_dma_trigger_select[3:0];
  wire logic ev = i_pub_event == 1;
  property p_none; i_generic_route_channel_id == 0 |=> {o_split_second, o_generic_channel} == 0; endproperty
  a_none: assert property (p_none) else $error("stray route");
  property p_p2p; ev && id inside {[1:4]} |=> o_generic_channel == 6'h1 << ($past(id) - 1); endproperty
  a_p2p: assert property (p_p2p) else $error("p2p route");
  property p_sp7; ev && id == 7 |=> o_generic_channel[4] && o_split_second == 1; endproperty
  a_sp7: assert property (p_sp7) else $error("split 7");
  property p_sp8; ev && id == 8 |-> ##1 o_generic_channel == 6'h20 && o_split_second == 2; endproperty
  a_sp8: assert property (p_sp8) else $error("split 8");
  property p_sw; ts == 0 |=> o_dma_trigger[0] == $past(i_sw_trigger[0]); endproperty
  a_sw: assert property (p_sw) else $error("sw trigger");
  property p_ser; ts inside {[3:14]} |=> o_dma_trigger[0] == $past(i_serial_pub[ts - 3]); endproperty
  a_ser: assert property (p_ser) else $error("serial trigger");
  property p_irq; 1 |=> o_irq[31] == $past(i_dma_irq) && o_irq[0] == $past(i_system_control_unit_irq); endproperty
  a_irq: assert property (p_irq) else $error("fixed irq");
  property p_stat; 1 |=> o_irq[29:1] == $past(i_other_irq[29:1]); endproperty
  a_stat: assert property (p_stat) else $error("static irq");
endmodule
bind event_fabric event_fabric_sva i_sva (.*);

// file: tb/tb_top.sv
module tb_top;
  timeunit 1ns / 1ns;
  logic i_clk = 0, i_sys_rst = 1, i_converter_dma_trigger = 0;
  logic [3:0] i_pub_event = 0;
  logic [15:0] i_generic_route_channel_id = 0;
  logic [2:0] i_sw_trigger = 0;
  logic [11:0] i_serial_pub = 0, i_dma_trigger_select = 0;
  logic [36:0] v = 0;
  logic [31:0] e;
  wire logic i_system_control_unit_irq = v[32], i_dma_irq = v[33], i_low_freq_subsystem_irq = v[34];
  wire logic i_rtc_irq = v[35], i_independent_watchdog_irq = v[36];
  wire logic [31:0] i_other_irq = v[31:0], o_irq;
  wire logic o_generic_subscriber_port_a, o_generic_subscriber_port_b, o_cpu_generic_event;
  wire logic [5:0] o_generic_channel;
  wire logic [1:0] o_split_second;
  wire logic [2:0] o_dma_trigger;
  int miscompares = 0, checks_done = 0, n;
  event_fabric i_dut (.*);
  dma_trigger_sink i_sink (.i_clk, .i_sys_rst, .i_trig(o_dma_trigger[0]), .o_count(n));
  initial forever #25 i_clk = ~i_clk;
  task automatic step(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] g, x);
    checks_done++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic t_route;
    for (int d = 0; d < 16; d++) begin
      i_generic_route_channel_id = 16'(d);
      i_pub_event = 1;
      step(2);
      e = d inside {[1:4]} ? 1 << (d - 1) : d == 6 ? 'h10 : d == 7 ? 'h50 : d == 8 ? 'ha0 : 0;
      chk({o_generic_subscriber_port_a, o_generic_subscriber_port_b, o_cpu_generic_event, o_split_second, o_generic_channel}, {d == 1, d == 2, d == 3, e[7:0]});
    end
    $display("t_route done");
  endtask
  task automatic t_trig;
    i_generic_route_channel_id = 'h21;
    for (int s = 0; s < 16; s++)
      for (int j = 0; j < 16; j++) begin
        i_dma_trigger_select = {3{4'(s)}};
        i_sw_trigger = {3{j == 0}};
        i_pub_event = {2'b0, j == 2, j == 1};
        i_serial_pub = 12'(16'h1 << j >> 3);
        i_converter_dma_trigger = j == 15;
        v = 37'h1 << (s * 16 + j) % 37;
        e = {v[33], |v[36:34], v[29:1], v[32]};
        step(3);
        chk({o_irq, o_generic_subscriber_port_b, o_dma_trigger}, {e, j == 2, {3{s == j}}});
      end
    i_converter_dma_trigger = 0;
    step(3);
    chk(n, 48);
    $display("t_trig done");
  endtask
  task automatic stop_test;
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    step(20);
    chk({o_irq, o_dma_trigger, o_split_second, o_generic_channel}, 0);
    i_sys_rst = 0;
    step(1);
    t_route();
    t_trig();
    stop_test();
  end
  initial begin
    step(5000);
    miscompares++;
    stop_test();
  end
endmodule
